//--- vpp_cfg.svh
// timing, encoding and reset constants for the packet port
`ifndef VPP_CFG_SVH
`define VPP_CFG_SVH
`define VPP_CLK_HZ 40000000
`define VPP_RATE0_HZ 28800
`define VPP_RATE1_HZ 57600
`define VPP_RATE2_HZ 115200
`define VPP_RATE3_HZ 230400
`define VPP_RATE4_HZ 460800
`define VPP_RATE5_HZ 921600
`define VPP_DIV_W 10
`define VPP_SEL_UART 2'h0
`define VPP_SEL_PAR 2'h1
`define VPP_SEL_SER 2'h2
`define VPP_BITS_PER_FRAME 4'h8
`define VPP_SYNC_W 19
`define VPP_SYNC_RST 19'h00003
`endif

//--- vpp_pkg.sv
// types shared by the packet port modules
package vpp_pkg;
   typedef logic [7:0] vpp_byte_t;
   typedef enum logic [1:0] {PAR_IDLE, PAR_RD_DRIVE, PAR_RD_ACK, PAR_WR_ACK} vpp_par_e;
endpackage : vpp_pkg

//--- vpp_byte_buf.sv
// two-entry byte buffer with valid/ready on both sides
`timescale 1ns/1ps
module vpp_byte_buf #(
   parameter int W = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // fill side
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   // drain side
   output logic out_valid,
   output logic [W-1:0] out_data,
   input wire logic out_ready
);
   logic [1:0] cnt_r;
   logic [1:0] cnt_nxt;
   logic [W-1:0] tail_r;
   logic push;
   logic pop;

   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign cnt_nxt = 2'(cnt_r + {1'b0, push} - {1'b0, pop});

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cnt_r <= 2'h0;
         in_ready <= 1'b1;
         out_valid <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         in_ready <= (cnt_nxt != 2'h2);
         out_valid <= (cnt_nxt != 2'h0);
      end
   end

   // strict arrival order: tail only ever moves into head
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         out_data <= '0;
         tail_r <= '0;
      end else begin
         if (pop) begin
            if (cnt_r == 2'h2) begin
               out_data <= tail_r;
            end else if (push) begin
               out_data <= in_data;
            end
            if (push && cnt_r == 2'h2) begin
               tail_r <= in_data;
            end
         end else if (push) begin
            if (cnt_r == 2'h0) begin
               out_data <= in_data;
            end else begin
               tail_r <= in_data;
            end
         end
      end
   end

   a_buf_fifo_order: assert property (@(posedge clk) disable iff (sys_rst)
      (push && cnt_r == 2'h1 && !pop) ##1 pop |=> out_data == $past(in_data, 2))
      else $error("buffer lost arrival order");
   a_buf_full_flag: assert property (@(posedge clk) disable iff (sys_rst)
      !in_ready |-> cnt_r == 2'h2 && out_valid)
      else $error("buffer ready low while not full");
endmodule : vpp_byte_buf

//--- vpp_packet_port.sv
// packet transport port: framed serial link or strobe/acknowledge parallel bus
`timescale 1ns/1ps
`include "vpp_cfg.svh"
module vpp_packet_port import vpp_pkg::*; (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // configuration pins
   input wire logic [1:0] port_sel,
   input wire logic [2:0] rate_sel,
   input wire logic codec_mode,
   // bytes from the packet engine
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic tx_is_chan,
   output logic tx_ready,
   // bytes to the packet engine
   output logic rx_valid,
   output logic [7:0] rx_data,
   input wire logic rx_ready,
   // framed serial port
   output logic ser_tx_data,
   output logic ser_tx_clk,
   output logic ser_tx_frame,
   input wire logic ser_rx_data,
   input wire logic ser_rx_clk,
   input wire logic ser_rx_frame,
   // parallel port
   input wire logic [7:0] par_data_in,
   output logic [7:0] par_data_out,
   output logic par_data_oe_n,
   input wire logic par_rd_req_n,
   input wire logic par_wr_req_n,
   output logic par_ack,
   output logic tx_rdy
);
   logic [`VPP_SYNC_W-1:0] sync1_r;
   logic [`VPP_SYNC_W-1:0] sync2_r;
   logic [1:0] sel_q;
   logic [2:0] rate_q;
   logic codec_q, rxd_q, rxc_q, rxf_q, rd_n_q, wr_n_q;
   logic [7:0] pdin_q;
   logic par_mode, ser_mode;
   vpp_byte_t hold_r;
   logic hold_full_r, hold_full_nxt, hold_pop, take, drop;
   logic [`VPP_DIV_W-1:0] div_cnt_r, half_sel;
   logic div_tick, txclk_rise;
   logic [3:0] tx_bits_r;
   vpp_byte_t tx_sh_r;
   logic ser_pop;
   logic rxc_d_r, rx_fall;
   logic [3:0] rx_cnt_r;
   vpp_byte_t rx_sh_r;
   logic ser_push;
   vpp_par_e par_st_r;
   logic par_pop, par_push, rd_start;
   logic buf_in_valid, buf_in_ready;
   vpp_byte_t buf_in_data;

   // all pins cross into clk through two flops
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sync1_r <= `VPP_SYNC_RST;
         sync2_r <= `VPP_SYNC_RST;
      end else begin
         sync1_r <= {port_sel, rate_sel, codec_mode, ser_rx_data, ser_rx_clk, ser_rx_frame,
                     par_data_in, par_rd_req_n, par_wr_req_n};
         sync2_r <= sync1_r;
      end
   end

   assign {sel_q, rate_q, codec_q, rxd_q, rxc_q, rxf_q, pdin_q, rd_n_q, wr_n_q} = sync2_r;
   assign par_mode = (sel_q == `VPP_SEL_PAR);
   assign ser_mode = (sel_q == `VPP_SEL_SER);

   // outgoing byte holding register shared by both transports
   assign take = tx_valid & tx_ready;
   assign drop = codec_q & par_mode & ~tx_is_chan;
   assign hold_pop = ser_pop | par_pop;
   assign hold_full_nxt = (hold_full_r & ~hold_pop) | (take & ~drop);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         hold_r <= 8'h00;
         hold_full_r <= 1'b0;
         tx_ready <= 1'b0;
         tx_rdy <= 1'b0;
      end else begin
         if (take) begin
            hold_r <= tx_data;
         end
         hold_full_r <= hold_full_nxt;
         tx_ready <= ~hold_full_nxt;
         tx_rdy <= par_mode & hold_full_nxt;
      end
   end

   // transmit clock divider; integer division rounds each rate slightly fast
   always_comb begin
      case (rate_q)
         3'h1: half_sel = `VPP_DIV_W'(`VPP_CLK_HZ / (2 * `VPP_RATE1_HZ));
         3'h2: half_sel = `VPP_DIV_W'(`VPP_CLK_HZ / (2 * `VPP_RATE2_HZ));
         3'h3: half_sel = `VPP_DIV_W'(`VPP_CLK_HZ / (2 * `VPP_RATE3_HZ));
         3'h4: half_sel = `VPP_DIV_W'(`VPP_CLK_HZ / (2 * `VPP_RATE4_HZ));
         3'h5: half_sel = `VPP_DIV_W'(`VPP_CLK_HZ / (2 * `VPP_RATE5_HZ));
         default: half_sel = `VPP_DIV_W'(`VPP_CLK_HZ / (2 * `VPP_RATE0_HZ));
      endcase
   end

   assign div_tick = ser_mode & (div_cnt_r >= half_sel - `VPP_DIV_W'(1));
   assign txclk_rise = div_tick & ~ser_tx_clk;

   always_ff @(posedge clk) begin
      if (sys_rst || !ser_mode) begin
         div_cnt_r <= '0;
         ser_tx_clk <= 1'b0;
      end else if (div_tick) begin
         div_cnt_r <= '0;
         ser_tx_clk <= ~ser_tx_clk;
      end else begin
         div_cnt_r <= div_cnt_r + `VPP_DIV_W'(1);
      end
   end

   // transmit shifter: frame one clock, then eight bits msb first
   assign ser_pop = txclk_rise & (tx_bits_r == 4'h0) & hold_full_r;

   always_ff @(posedge clk) begin
      if (sys_rst || !ser_mode) begin
         tx_bits_r <= 4'h0;
         tx_sh_r <= 8'h00;
         ser_tx_data <= 1'b0;
         ser_tx_frame <= 1'b0;
      end else if (txclk_rise) begin
         if (tx_bits_r != 4'h0) begin
            ser_tx_data <= tx_sh_r[7];
            tx_sh_r <= {tx_sh_r[6:0], 1'b0};
            tx_bits_r <= tx_bits_r - 4'h1;
            ser_tx_frame <= 1'b0;
         end else if (hold_full_r) begin
            tx_sh_r <= hold_r;
            tx_bits_r <= `VPP_BITS_PER_FRAME;
            ser_tx_frame <= 1'b1;
            ser_tx_data <= 1'b0;
         end else begin
            ser_tx_frame <= 1'b0;
            ser_tx_data <= 1'b0;
         end
      end
   end

   // receive shifter on host clock falling edges; a full buffer drops the byte
   assign rx_fall = rxc_d_r & ~rxc_q;
   assign ser_push = ser_mode & rx_fall & (rx_cnt_r == 4'h1);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rxc_d_r <= 1'b0;
         rx_cnt_r <= 4'h0;
         rx_sh_r <= 8'h00;
      end else begin
         rxc_d_r <= rxc_q;
         if (!ser_mode) begin
            rx_cnt_r <= 4'h0;
         end else if (rx_fall) begin
            if (rx_cnt_r != 4'h0) begin
               rx_sh_r <= {rx_sh_r[6:0], rxd_q};
               rx_cnt_r <= rx_cnt_r - 4'h1;
            end else if (rxf_q) begin
               rx_cnt_r <= `VPP_BITS_PER_FRAME;
            end
         end
      end
   end

   // parallel four-phase handshake; write waits for buffer room
   assign rd_start = (par_st_r == PAR_IDLE) & par_mode & ~rd_n_q & hold_full_r;
   assign par_push = (par_st_r == PAR_IDLE) & par_mode & ~rd_start & ~wr_n_q & buf_in_ready;
   assign par_pop = (par_st_r == PAR_RD_ACK) & par_mode & rd_n_q;

   always_ff @(posedge clk) begin
      if (sys_rst || !par_mode) begin
         par_st_r <= PAR_IDLE;
         par_ack <= 1'b1;
         par_data_oe_n <= 1'b1;
         par_data_out <= 8'h00;
      end else begin
         case (par_st_r)
            PAR_IDLE: begin
               if (rd_start) begin
                  par_data_out <= hold_r;
                  par_data_oe_n <= 1'b0;
                  par_st_r <= PAR_RD_DRIVE;
               end else if (par_push) begin
                  par_ack <= 1'b0;
                  par_st_r <= PAR_WR_ACK;
               end
            end
            PAR_RD_DRIVE: begin
               par_ack <= 1'b0;
               par_st_r <= PAR_RD_ACK;
            end
            PAR_RD_ACK: begin
               if (rd_n_q) begin
                  par_ack <= 1'b1;
                  par_data_oe_n <= 1'b1;
                  par_st_r <= PAR_IDLE;
               end
            end
            PAR_WR_ACK: begin
               if (wr_n_q) begin
                  par_ack <= 1'b1;
                  par_st_r <= PAR_IDLE;
               end
            end
            default: begin
               par_st_r <= PAR_IDLE;
               par_ack <= 1'b1;
            end
         endcase
      end
   end

   // one receive queue for whichever port is active
   assign buf_in_valid = ser_push | par_push;
   assign buf_in_data = par_push ? pdin_q : {rx_sh_r[6:0], rxd_q};

   vpp_byte_buf #(
      .W(8)
   ) u_rx_buf (
      .clk(clk),
      .sys_rst(sys_rst),
      .in_valid(buf_in_valid),
      .in_data(buf_in_data),
      .in_ready(buf_in_ready),
      .out_valid(rx_valid),
      .out_data(rx_data),
      .out_ready(rx_ready)
   );

   a_ack_idle_high: assert property (@(posedge clk) disable iff (sys_rst)
      par_st_r == PAR_IDLE |-> par_ack)
      else $error("acknowledge low while idle");
   a_rd_data_first: assert property (@(posedge clk) disable iff (sys_rst)
      $fell(par_ack) && !par_data_oe_n |-> $past(!par_data_oe_n) && par_data_out == $past(hold_r, 2))
      else $error("read acknowledge before data driven");
   a_ack_rise_req: assert property (@(posedge clk) disable iff (sys_rst || !par_mode)
      $rose(par_ack) |-> $past(rd_n_q) && $past(wr_n_q))
      else $error("acknowledge raised while request low");
   a_wr_capture: assert property (@(posedge clk) disable iff (sys_rst)
      par_push |=> !par_ack && rx_valid)
      else $error("write not acknowledged");
   a_one_port: assert property (@(posedge clk) disable iff (sys_rst)
      !par_mode |=> par_ack && par_data_oe_n && !tx_rdy)
      else $error("parallel port active outside parallel mode");
   a_txrdy_level: assert property (@(posedge clk) disable iff (sys_rst)
      par_mode && hold_full_r && !hold_pop |=> tx_rdy)
      else $error("transmit ready low with byte waiting");
   a_tx_frame_len: assert property (@(posedge clk) disable iff (sys_rst || !ser_mode)
      $fell(ser_tx_frame) |-> tx_bits_r == 4'h7)
      else $error("frame does not open an eight-bit byte");
   a_tx_change_rise: assert property (@(posedge clk) disable iff (sys_rst || !ser_mode)
      $changed(ser_tx_data) || $changed(ser_tx_frame) |-> $rose(ser_tx_clk))
      else $error("transmit data changed off the rising edge");
   a_txclk_half: assert property (@(posedge clk) disable iff (sys_rst || !ser_mode)
      $changed(ser_tx_clk) && rate_q == $past(rate_q) && rate_q == $past(rate_q, 2) && $past(ser_mode)
      |-> $past(div_cnt_r) == half_sel - 10'h1)
      else $error("transmit clock half period wrong");
   a_rx_fall_only: assert property (@(posedge clk) disable iff (sys_rst || !ser_mode)
      $changed(rx_sh_r) |-> $past(rx_fall))
      else $error("receive bit taken off the falling edge");
   a_codec_filter: assert property (@(posedge clk) disable iff (sys_rst)
      take && drop |=> !hold_full_r)
      else $error("non-channel byte held in codec mode");
endmodule : vpp_packet_port

//--- vpp_host_model.sv
// host controller model: serial link peer and parallel bus master
`timescale 1ns/1ps
module vpp_host_model (
   // system clock
   input wire logic clk,
   // framed serial link
   output logic ser_rx_clk,
   output logic ser_rx_frame,
   output logic ser_rx_data,
   input wire logic ser_tx_clk,
   input wire logic ser_tx_frame,
   input wire logic ser_tx_data,
   // parallel bus
   output logic [7:0] par_data_in,
   input wire logic [7:0] par_data_out,
   input wire logic par_data_oe_n,
   output logic par_rd_req_n,
   output logic par_wr_req_n,
   input wire logic par_ack
);
   logic [7:0] host_d = 8'h00;
   logic [7:0] last_r = 8'h00;
   logic host_oe = 1'b0;
   // no pull on the bus: a floating bus toggles instead of keeping the old byte
   assign par_data_in = !par_data_oe_n ? par_data_out : host_oe ? host_d : ~last_r;
   always @(posedge clk) last_r <= par_data_in;
   initial begin
      ser_rx_clk = 1'b0;
      ser_rx_frame = 1'b0;
      ser_rx_data = 1'b0;
      par_rd_req_n = 1'b1;
      par_wr_req_n = 1'b1;
   end
   // clock only inside a frame; bit valid only around the falling edge
   // 1100 ns period keeps the host clock inside its allowed range
   task automatic ser_put(input logic [7:0] b);
      for (int i = 0; i < 9; i++) begin
         ser_rx_clk = 1'b1;
         #275 ser_rx_frame = (i == 0);
         ser_rx_data = (i == 0) ? ~ser_rx_data : b[8-i];
         #275 ser_rx_clk = 1'b0;
         #275 ser_rx_frame = 1'b0;
         ser_rx_data = ~ser_rx_data;
         #275;
      end
   endtask : ser_put
   // values just before a tx clock rise; data moves with the rise itself
   task automatic tx_rise(output logic fr, output logic d);
      logic [2:0] p;
      logic [2:0] c;
      c = {ser_tx_clk, ser_tx_frame, ser_tx_data};
      do begin
         p = c;
         @(posedge clk);
         #1 c = {ser_tx_clk, ser_tx_frame, ser_tx_data};
      end while (!(c[2] && !p[2]));
      {fr, d} = p[1:0];
   endtask : tx_rise
   task automatic ser_get(output logic [7:0] b, output logic ok);
      logic fr;
      logic d;
      ok = 1'b0;
      for (int n = 0; n < 40 && !ok; n++) begin
         tx_rise(fr, d);
         ok = (fr === 1'b1);
      end
      for (int i = 7; i >= 0; i--) begin
         tx_rise(fr, d);
         b[i] = d;
         ok = ok & (fr === 1'b0);
      end
   endtask : ser_get
   task automatic wait_ack(input logic lvl, output logic ok);
      ok = 1'b0;
      for (int n = 0; n < 300 && !ok; n++) begin
         @(posedge clk);
         #1 ok = (par_ack === lvl);
      end
   endtask : wait_ack
   task automatic par_write(input logic [7:0] b, output logic ok);
      logic ok2;
      host_d = b;
      host_oe = 1'b1;
      @(posedge clk);
      #1 par_wr_req_n = 1'b0;
      wait_ack(1'b0, ok);
      repeat (3) @(posedge clk);
      #1 par_wr_req_n = 1'b1;
      wait_ack(1'b1, ok2);
      host_oe = 1'b0;
      @(posedge clk);
      #1 ok = ok & ok2;
   endtask : par_write
   task automatic par_read(output logic [7:0] b, output logic ok);
      logic ok2;
      par_rd_req_n = 1'b0;
      wait_ack(1'b0, ok);
      b = par_data_in;
      ok = ok & (par_data_oe_n === 1'b0);
      @(posedge clk);
      #1 par_rd_req_n = 1'b1;
      wait_ack(1'b1, ok2);
      ok = ok & ok2;
   endtask : par_read
endmodule : vpp_host_model

//--- tb.sv
// bench for the packet port against the host model
`timescale 1ns/1ps
`include "vpp_cfg.svh"
module tb import vpp_pkg::*; ;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [1:0] port_sel = `VPP_SEL_UART;
   logic [2:0] rate_sel = 3'h5;
   logic codec_mode = 1'b0;
   logic tx_valid = 1'b0;
   logic tx_is_chan = 1'b0;
   logic rx_ready = 1'b0;
   vpp_byte_t tx_data = 8'h00;
   vpp_byte_t rx_data, par_data_in, par_data_out;
   logic tx_ready, rx_valid, ser_tx_data, ser_tx_clk, ser_tx_frame, ser_rx_data, ser_rx_clk, ser_rx_frame;
   logic par_data_oe_n, par_rd_req_n, par_wr_req_n, par_ack, tx_rdy;
   int err_count = 0;
   int num_checks = 0;
   vpp_packet_port dut (.clk, .sys_rst, .port_sel, .rate_sel, .codec_mode, .tx_valid, .tx_data, .tx_is_chan,
      .tx_ready, .rx_valid, .rx_data, .rx_ready, .ser_tx_data, .ser_tx_clk, .ser_tx_frame, .ser_rx_data,
      .ser_rx_clk, .ser_rx_frame, .par_data_in, .par_data_out, .par_data_oe_n, .par_rd_req_n, .par_wr_req_n,
      .par_ack, .tx_rdy);
   vpp_host_model host (.clk, .ser_rx_clk, .ser_rx_frame, .ser_rx_data, .ser_tx_clk, .ser_tx_frame,
      .ser_tx_data, .par_data_in, .par_data_out, .par_data_oe_n, .par_rd_req_n, .par_wr_req_n, .par_ack);
   initial begin
      forever #12.5 clk = ~clk;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   task automatic set_mode(input logic [1:0] sel, input logic codec);
      port_sel = sel;
      codec_mode = codec;
      step(6);
   endtask : set_mode
   task automatic send_byte(input vpp_byte_t b, input logic chan);
      tx_valid = 1'b1;
      tx_data = b;
      tx_is_chan = chan;
      for (int n = 0; n < 5000 && tx_ready !== 1'b1; n++) step(1);
      step(1);
      tx_valid = 1'b0;
      step(1);
   endtask : send_byte
   task automatic pop(input vpp_byte_t exp);
      for (int n = 0; n < 400 && rx_valid !== 1'b1; n++) step(1);
      check(rx_data, exp);
      rx_ready = 1'b1;
      step(1);
      rx_ready = 1'b0;
      step(1);
   endtask : pop
   task automatic clk_phase(input logic lvl, output int n);
      for (n = 0; n < 3000 && ser_tx_clk !== lvl; n++) step(1);
   endtask : clk_phase
   task automatic t_rates;
      int h;
      set_mode(`VPP_SEL_SER, 1'b0);
      for (int i = 0; i < 8; i++) begin
         rate_sel = 3'(i);
         // skip the phase that may still run at the old rate
         for (int k = 0; k < 4; k++) clk_phase(k % 2 == 0, h);
         check(16'(h), 16'(`VPP_CLK_HZ / (2 * (`VPP_RATE0_HZ << (i > 5 ? 0 : i)))));
      end
      rate_sel = 3'h5;
      step(20);
   endtask : t_rates
   task automatic t_serial;
      vpp_byte_t b1, b2;
      logic ok1, ok2;
      fork
         begin
            send_byte(8'hA5, 1'b0);
            send_byte(8'h3C, 1'b0);
         end
         begin
            host.ser_get(b1, ok1);
            host.ser_get(b2, ok2);
         end
      join
      check({b1, b2}, 16'hA53C);
      check({ok1, ok2}, 2'h3);
      host.ser_put(8'h96);
      host.ser_put(8'h4B);
      pop(8'h96);
      pop(8'h4B);
   endtask : t_serial
   task automatic t_par_read;
      vpp_byte_t b;
      logic ok;
      logic hi = 1'b0;
      set_mode(`VPP_SEL_PAR, 1'b0);
      for (int n = 0; n < 100; n++) begin
         step(1);
         hi |= ser_tx_clk | ser_tx_frame;
      end
      check(hi, 1'b0);
      send_byte(8'hC3, 1'b0);
      step(2);
      check(tx_rdy, 1'b1);
      host.par_read(b, ok);
      check({b, ok}, {8'hC3, 1'b1});
      check({tx_rdy, par_data_oe_n, par_ack, tx_ready}, 4'h7);
      set_mode(`VPP_SEL_PAR, 1'b1);
      send_byte(8'h11, 1'b0);
      step(10);
      check(tx_rdy, 1'b0);
      send_byte(8'h22, 1'b1);
      host.par_read(b, ok);
      check({b, ok}, {8'h22, 1'b1});
      set_mode(`VPP_SEL_PAR, 1'b0);
   endtask : t_par_read
   task automatic t_par_write;
      logic ok1, ok2, ok3;
      host.par_write(8'h5A, ok1);
      host.par_write(8'hA5, ok2);
      fork
         host.par_write(8'h77, ok3);
         begin
            step(40);
            check(par_ack, 1'b1);
            pop(8'h5A);
         end
      join
      check({ok1, ok2, ok3}, 3'h7);
      pop(8'hA5);
      pop(8'h77);
      step(4);
      check(rx_valid, 1'b0);
   endtask : t_par_write
   task automatic conclude;
      if (err_count == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : conclude
   initial begin
      repeat (3) @(posedge clk);
      #1 sys_rst = 1'b0;
      step(4);
      check({par_ack, par_data_oe_n, tx_rdy, ser_tx_clk}, 4'hC);
      t_rates();
      t_serial();
      t_par_read();
      t_par_write();
      conclude();
   end
   initial begin
      #2000000;
      err_count++;
      conclude();
   end
endmodule : tb
